// ==== include/pump_tune_pkg.sv ====
// Purpose: shared constants for the pump override and VCO tune sequencer
// Assumes: 32-bit classic Wishbone, word index = byte address / 4
// Notes: all registers reset to zero; indices are word indices

package pump_tune_pkg;

	// ----------------------------------------------------------------
	// register word indices
	// ----------------------------------------------------------------
	localparam logic [4:0] IDX_STATUS = 5'h00;
	localparam logic [4:0] IDX_FREQ_FIRST = 5'h06;
	localparam logic [4:0] IDX_FREQ_LAST = 5'h0A;
	localparam logic [4:0] IDX_PUMP = 5'h0D;
	localparam logic [4:0] IDX_TUNE = 5'h0E;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	// pump control register
	localparam int P_FORCE_SOURCE = 0;
	localparam int P_FORCE_SINK = 1;
	localparam int P_DETECTOR_RESET = 2;
	localparam int P_MID_BIAS = 3;
	localparam int P_HIGH_CLAMP_EN = 4;
	localparam int P_LOW_CLAMP_EN = 5;
	localparam int P_PHASE_INVERT = 6;
	localparam int P_LINEARIZER_EN = 7;
	localparam int P_WIDE_PULSE = 8;
	// tune control register
	localparam int T_START = 0;
	localparam int T_AUTO = 1;
	localparam int T_MUTE = 2;
	localparam int T_INT_MODE = 3;
	localparam int T_SEL_LSB = 4;
	// status register
	localparam int S_HIGH_FLAG = 0;
	localparam int S_LOW_FLAG = 1;
	localparam int S_BUSY = 2;
	localparam int S_TUNED = 3;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [8:0] PUMP_RESET = 9'h000;
	localparam logic [7:0] TUNE_RESET = 8'h00;
	localparam logic [7:0] FREQ_RESET = 8'h00;
	// divided clocks per tune cycle, inside the 12..14 window
	localparam logic [3:0] TUNE_TICKS = 4'hD;

	// ----------------------------------------------------------------
	// prescale code to divide value
	// ----------------------------------------------------------------
	function automatic logic [8:0] divValue(input logic [3:0] sel);
		case (sel)
			4'h0: divValue = 9'h008;
			4'h1: divValue = 9'h00C;
			4'h2: divValue = 9'h010;
			4'h3: divValue = 9'h018;
			4'h4: divValue = 9'h020;
			4'h5: divValue = 9'h030;
			4'h6: divValue = 9'h040;
			4'h7: divValue = 9'h060;
			4'h8: divValue = 9'h080;
			4'h9: divValue = 9'h0C0;
			4'hA: divValue = 9'h100;
			4'hB: divValue = 9'h180;
			default: divValue = 9'h000;
		endcase
	endfunction

endpackage

// ==== include/tune_if.sv ====
// Purpose: link between tune sequencer and its prescaler
// Assumes: one clock, clk_sys
// Notes: tuneTick is a one-cycle enable at the divided rate

interface tune_if;
	logic restart;
	logic [3:0] divSel;
	logic tuneTick;

	modport seq (output restart, output divSel, input tuneTick);
	modport pre (input restart, input divSel, output tuneTick);
endinterface

// ==== src/pump_tune_ctrl.sv ====
// Purpose: pump override controls and VCO tune sequencer
// Assumes: classic Wishbone slave, 32-bit data, one clock
// Notes: reset stands for power cycle and software power-on reset
//
// Decided for this implementation: register access over Wishbone and the address map.

module pump_tune_ctrl
	import pump_tune_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [6:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// analog side inputs
	input wire logic clampHighIn,
	input wire logic clampLowIn,
	input wire logic pfdRateIn,
	// pump controls
	output logic forceSource,
	output logic forceSink,
	output logic sourceInhibit,
	output logic sinkInhibit,
	output logic midBias,
	output logic phaseInvert,
	output logic widePulse,
	output logic linearizerOn,
	output logic detectorHold,
	// modulator and rf
	output logic modulatorStandby,
	output logic rfMute,
	// tune state
	output logic tuneBusy,
	output logic tuneValid
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} tune_state_t;

	typedef struct packed {
		// bus
		logic ack;
		logic [8:0] rdat;
		// software registers
		logic [8:0] pump;
		logic [7:0] tune;
		logic [4:0][7:0] freq;
		// comparator synchronisers
		logic [2:0] hiSync;
		logic [2:0] loSync;
		logic hiLvl;
		logic loLvl;
		// sequencer
		tune_state_t state;
		logic [3:0] tickCnt;
		logic restart;
		logic tuned;
		// registered outputs
		logic hiFlag;
		logic loFlag;
		logic linOn;
		logic mute;
	} ctrl_t;

	ctrl_t q, d;
	tune_if tp ();

	logic access;
	logic wrCommit;
	logic [4:0] idx;
	logic inFreq;
	logic startReq;
	logic selOk;

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	tune_prescaler prescaler (
		.clk_sys(clk_sys),
		.reset(reset),
		.pfdRateIn(pfdRateIn),
		.tp(tp)
	);

	// select is frozen while tuning, so the divider never moves mid-cycle
	assign tp.divSel = q.tune[T_SEL_LSB +: 4];
	assign tp.restart = q.restart;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	function automatic logic [8:0] readMux(input ctrl_t s, input logic [4:0] i);
		logic [7:0] t;
		t = s.tune;
		// start bit shows the cycle in flight
		t[T_START] = (s.state == ST_RUN);
		case (i)
			IDX_STATUS: readMux = {5'h00, s.tuned, s.state == ST_RUN, s.loFlag, s.hiFlag};
			IDX_PUMP: readMux = s.pump;
			IDX_TUNE: readMux = {1'b0, t};
			5'h06: readMux = {1'b0, s.freq[0]};
			5'h07: readMux = {1'b0, s.freq[1]};
			5'h08: readMux = {1'b0, s.freq[2]};
			5'h09: readMux = {1'b0, s.freq[3]};
			5'h0A: readMux = {1'b0, s.freq[4]};
			default: readMux = 9'h000;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// writes commit on the edge where the master samples ack
	always_comb begin
		d = q;
		access = cyc_i & stb_i;
		idx = adr_i[6:2];
		wrCommit = access & we_i & q.ack;
		inFreq = (idx >= IDX_FREQ_FIRST) && (idx <= IDX_FREQ_LAST);
		d.ack = access & ~q.ack;
		d.restart = 1'b0;
		if (access & ~q.ack) begin
			d.rdat = readMux(q, idx);
		end

		// register writes, low byte lane plus one bit of lane one
		if (wrCommit & sel_i[0]) begin
			if (idx == IDX_PUMP) begin
				d.pump[7:0] = dat_i[7:0];
			end
			if (idx == IDX_TUNE && q.state != ST_RUN) begin
				d.tune = dat_i[7:0];
				d.tune[T_START] = 1'b0;
			end
			if (inFreq) begin
				d.freq[idx - IDX_FREQ_FIRST] = dat_i[7:0];
			end
		end
		if (wrCommit & sel_i[1] & (idx == IDX_PUMP)) begin
			d.pump[P_WIDE_PULSE] = dat_i[8];
		end
		// judge the code that will be in force, not the one being replaced
		selOk = divValue(d.tune[T_SEL_LSB +: 4]) != 9'h000;

		// start by explicit write or by auto tune on frequency register writes
		startReq = wrCommit & sel_i[0] & (idx == IDX_TUNE) & dat_i[T_START];
		startReq = startReq | (wrCommit & sel_i[0] & inFreq & q.tune[T_AUTO]);

		// sequencer
		case (q.state)
			ST_IDLE: begin
				// invalid prescale code refuses the start
				if (startReq & selOk) begin
					d.state = ST_RUN;
					d.tickCnt = 4'h0;
					d.restart = 1'b1;
				end
			end
			ST_RUN: begin
				// a tick already in flight when the divider restarts is stale
				if (tp.tuneTick & ~q.restart) begin
					if (q.tickCnt == TUNE_TICKS - 4'h1) begin
						d.state = ST_IDLE;
						d.tickCnt = 4'h0;
						d.tuned = 1'b1;
					end else begin
						d.tickCnt = q.tickCnt + 4'h1;
					end
				end
			end
			default: begin
				d.state = ST_IDLE;
			end
		endcase

		// comparators: accept a level once stages two and three agree
		d.hiSync = {q.hiSync[1:0], clampHighIn};
		d.loSync = {q.loSync[1:0], clampLowIn};
		if (q.hiSync[1] == q.hiSync[2]) begin
			d.hiLvl = q.hiSync[2];
		end
		if (q.loSync[1] == q.loSync[2]) begin
			d.loLvl = q.loSync[2];
		end
		d.hiFlag = d.hiLvl & d.pump[P_HIGH_CLAMP_EN];
		d.loFlag = d.loLvl & d.pump[P_LOW_CLAMP_EN];

		// linearizer off in integer mode, whatever its enable says
		d.linOn = d.pump[P_LINEARIZER_EN] & ~d.tune[T_INT_MODE];
		d.mute = (d.state == ST_RUN) & d.tune[T_MUTE];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// a reset is the only thing that drops the tune result
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
			q.pump <= PUMP_RESET;
			q.tune <= TUNE_RESET;
			q.freq <= {5{FREQ_RESET}};
			q.state <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dat_o = {23'h000000, q.rdat};
	assign ack_o = q.ack;
	assign forceSource = q.pump[P_FORCE_SOURCE];
	assign forceSink = q.pump[P_FORCE_SINK];
	// clamp cuts current on the side driving toward the rail
	assign sourceInhibit = q.hiFlag;
	assign sinkInhibit = q.loFlag;
	assign midBias = q.pump[P_MID_BIAS];
	assign phaseInvert = q.pump[P_PHASE_INVERT];
	assign widePulse = q.pump[P_WIDE_PULSE];
	assign linearizerOn = q.linOn;
	assign detectorHold = q.pump[P_DETECTOR_RESET];
	assign modulatorStandby = q.tune[T_INT_MODE];
	assign rfMute = q.mute;
	assign tuneBusy = (q.state == ST_RUN);
	assign tuneValid = q.tuned;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	// count divided ticks seen during a cycle
	logic [4:0] ticksSeen;
	always_ff @(posedge clk_sys) begin
		if (reset || !tuneBusy) begin
			ticksSeen <= 5'h00;
		end else if (tp.tuneTick && !q.restart) begin
			ticksSeen <= ticksSeen + 5'h01;
		end
	end

	ack_one_cycle_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property ($rose(cyc_i & stb_i) && !ack_o |=> ack_o)
		else $error("ack missing one cycle after request");
	high_clamp_a: assert property (q.hiLvl && q.pump[P_HIGH_CLAMP_EN] |-> sourceInhibit)
		else $error("high clamp did not inhibit sourcing");
	low_clamp_a: assert property (q.loLvl && q.pump[P_LOW_CLAMP_EN] |-> sinkInhibit)
		else $error("low clamp did not inhibit sinking");
	clamp_follow_a: assert property (!q.pump[P_HIGH_CLAMP_EN] |-> !sourceInhibit)
		else $error("high flag set with clamp disabled");
	lin_intmode_a: assert property (modulatorStandby |-> !linearizerOn)
		else $error("linearizer on in integer mode");
	tune_length_a: assert property ($fell(tuneBusy) |-> ticksSeen >= 5'h0C && ticksSeen <= 5'h0E)
		else $error("tune cycle length outside window");
	tune_mute_a: assert property (tuneBusy && q.tune[T_MUTE] |-> rfMute)
		else $error("rf not muted during tune");
	auto_start_a: assert property (wrCommit && sel_i[0] && inFreq && q.tune[T_AUTO]
		&& !tuneBusy && selOk |=> tuneBusy)
		else $error("auto tune did not start");
	result_hold_a: assert property (tuneValid |=> tuneValid)
		else $error("tune result lost without reset");
	done_flag_a: assert property ($fell(tuneBusy) |-> tuneValid)
		else $error("tune finished without result flag");
	force_drive_a: assert property (q.pump[P_FORCE_SOURCE] |-> forceSource)
		else $error("force source not driven");
	// bus answers only to a request
	ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	// pump writes reach the override pins one edge after commit
	pump_write_a: assert property (wrCommit && sel_i[0] && idx == IDX_PUMP
		|=> forceSource == $past(dat_i[P_FORCE_SOURCE])
		&& forceSink == $past(dat_i[P_FORCE_SINK]))
		else $error("force bits did not follow write");
	wide_write_a: assert property (wrCommit && sel_i[1] && idx == IDX_PUMP
		|=> widePulse == $past(dat_i[P_WIDE_PULSE]))
		else $error("wide pulse did not follow write");
	hold_write_a: assert property (wrCommit && sel_i[0] && idx == IDX_PUMP
		|=> detectorHold == $past(dat_i[P_DETECTOR_RESET]))
		else $error("detector hold did not follow write");
	standby_write_a: assert property (wrCommit && sel_i[0] && idx == IDX_TUNE
		&& !tuneBusy |=> modulatorStandby == $past(dat_i[T_INT_MODE]))
		else $error("standby did not follow write");
	// tuning register is closed while a cycle runs
	busy_write_a: assert property (wrCommit && idx == IDX_TUNE && tuneBusy
		|=> $stable(q.tune))
		else $error("tune register changed while busy");
	tune_start_a: assert property (startReq && !tuneBusy && selOk |=> tuneBusy)
		else $error("valid start did not begin a cycle");
	bad_code_a: assert property (startReq && !tuneBusy && !selOk |=> !tuneBusy)
		else $error("invalid prescale code started a cycle");
	restart_a: assert property ($rose(tuneBusy) |-> tp.restart)
		else $error("prescaler not restarted at cycle start");
	start_clear_a: assert property (!tuneBusy |-> !q.tune[T_START])
		else $error("start bit left set while idle");
	mute_clear_a: assert property ($fell(tuneBusy) |-> !rfMute)
		else $error("rf mute held after tune cycle");
	low_follow_a: assert property (!q.pump[P_LOW_CLAMP_EN] |-> !sinkInhibit)
		else $error("low flag set with clamp disabled");
	lin_follow_a: assert property (q.pump[P_LINEARIZER_EN] && !modulatorStandby |-> linearizerOn)
		else $error("linearizer off in fractional mode");

endmodule

// ==== src/tune_prescaler.sv ====
// Purpose: divides the phase-detector rate into tune enable pulses
// Assumes: pfdRateIn is asynchronous to clk_sys
// Notes: restart realigns the count so a cycle starts cleanly

module tune_prescaler
	import pump_tune_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// phase-detector rate pin
	input wire logic pfdRateIn,
	// sequencer side
	tune_if.pre tp
);

	typedef struct packed {
		logic [2:0] sync;
		logic lvl;
		logic [8:0] cnt;
		logic tick;
	} pre_t;

	pre_t q, d;
	logic edgeSeen;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	// accept a level only once second and third stage agree
	always_comb begin
		d = q;
		d.sync = {q.sync[1:0], pfdRateIn};
		d.tick = 1'b0;
		if (q.sync[1] == q.sync[2]) begin
			d.lvl = q.sync[2];
		end
		edgeSeen = d.lvl & ~q.lvl;
		if (tp.restart) begin
			d.cnt = 9'h000;
		end else if (edgeSeen) begin
			if (q.cnt >= divValue(tp.divSel) - 9'h001) begin
				d.cnt = 9'h000;
				d.tick = 1'b1;
			end else begin
				d.cnt = q.cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tp.tuneTick = q.tick;

endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for pump controls and tune sequencer
// Assumes: phase-detector rate of one quarter of clk_sys
// Notes: each of the twelve valid prescale codes is tuned by an explicit start, so the run is long

module tb;
	import pump_tune_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic clampHighIn = 1'b0;
	logic clampLowIn = 1'b0;
	logic pfdRateIn = 1'b0;
	logic [1:0] pfdCnt = 2'h0;
	logic cyc, stb, we, ack;
	logic [6:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, datIn;
	logic forceSource, forceSink, sourceInhibit, sinkInhibit, midBias, phaseInvert;
	logic widePulse, linearizerOn, detectorHold, modulatorStandby, rfMute, tuneBusy, tuneValid;
	logic [31:0] r;
	int error_cnt = 0;
	int checked = 0;
	int divTab[12] = '{8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256, 384};

	// ------------------------------------------------------------
	// clock and far-side stimulus
	// ------------------------------------------------------------
	always #2 clk_sys = ~clk_sys;
	// slow square wave keeps each edge visible through the synchronizer
	always @(posedge clk_sys) begin
		pfdCnt <= pfdCnt + 2'h1;
		pfdRateIn <= pfdCnt[1];
	end

	wb_host host (.clk_sys, .cyc, .stb, .we, .adr, .sel, .dat, .ack, .datIn);
	pump_tune_ctrl uut (.clk_sys, .reset, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(dat), .dat_o(datIn), .ack_o(ack), .clampHighIn, .clampLowIn,
		.pfdRateIn, .forceSource, .forceSink, .sourceInhibit, .sinkInhibit, .midBias,
		.phaseInvert, .widePulse, .linearizerOn, .detectorHold, .modulatorStandby, .rfMute,
		.tuneBusy, .tuneValid);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		if (error_cnt == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [4:0] idx, input logic [31:0] d);
		bit hung;
		host.xfer(w, idx, d, r, hung);
		if (hung) begin
			$display("BAD %0t bus timeout", $time);
			error_cnt++;
			tally_and_finish();
		end
	endtask

	// counts cycles until the sequencer goes idle
	task automatic waitIdle(output int n);
		n = 0;
		while (tuneBusy === 1'b1 && n < 30000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 30000) begin
			$display("BAD %0t tune timeout", $time);
			error_cnt++;
			tally_and_finish();
		end
	endtask

	// one tune run; a write while busy must change nothing
	task automatic tune(input logic [3:0] code, input logic m);
		int n;
		int b;
		b = divTab[code];
		acc(1'b1, IDX_TUNE, {24'h0, code, 1'b0, m, 2'b01});
		chk(tuneBusy, 1'b1);
		chk(rfMute, m);
		acc(1'b1, IDX_TUNE, 32'h000000F6);
		acc(1'b0, IDX_TUNE, 32'h0);
		chk(r, {24'h0, code, 1'b0, m, 2'b01});
		waitIdle(n);
		chk(n >= 12 * b * 4 - 16 && n <= 14 * b * 4 + 12, 1'b1);
		chk(rfMute, 1'b0);
		chk(tuneValid, 1'b1);
		acc(1'b0, IDX_TUNE, 32'h0);
		chk(r[0], 1'b0);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int n;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		chk({forceSource, forceSink, sourceInhibit, sinkInhibit, midBias, phaseInvert,
			widePulse, linearizerOn, detectorHold, modulatorStandby, rfMute, tuneBusy,
			tuneValid}, 32'h0);
		acc(1'b0, IDX_PUMP, 32'h0);
		chk(r, {23'h0, PUMP_RESET});
		// overrides, precharge with detector held
		acc(1'b1, IDX_PUMP, 32'h00000145);
		repeat (2) @(posedge clk_sys);
		chk({forceSource, forceSink, detectorHold, midBias, phaseInvert, widePulse},
			6'b101011);
		acc(1'b1, IDX_PUMP, 32'h0000000E);
		repeat (2) @(posedge clk_sys);
		chk({forceSource, forceSink, detectorHold, midBias}, 4'b0111);
		acc(1'b0, IDX_PUMP, 32'h0);
		chk(r, 32'h0000000E);
		// linearizer against integer mode
		acc(1'b1, IDX_PUMP, 32'h00000080);
		acc(1'b1, IDX_TUNE, 32'h00000008);
		repeat (2) @(posedge clk_sys);
		chk({linearizerOn, modulatorStandby}, 2'b01);
		acc(1'b1, IDX_TUNE, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk({linearizerOn, modulatorStandby}, 2'b10);
		// clamps follow comparators only while enabled
		acc(1'b1, IDX_PUMP, 32'h00000030);
		clampHighIn <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk({sourceInhibit, sinkInhibit}, 2'b10);
		acc(1'b0, IDX_STATUS, 32'h0);
		chk(r, 32'h00000001);
		clampHighIn <= 1'b0;
		clampLowIn <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk({sourceInhibit, sinkInhibit}, 2'b01);
		acc(1'b0, IDX_STATUS, 32'h0);
		chk(r, 32'h00000002);
		acc(1'b1, IDX_PUMP, 32'h0);
		repeat (6) @(posedge clk_sys);
		chk({sourceInhibit, sinkInhibit}, 2'b00);
		clampLowIn <= 1'b0;
		// invalid prescale codes refuse the start
		for (int c = 12; c < 16; c++) begin
			acc(1'b1, IDX_TUNE, {24'h0, c[3:0], 4'h1});
			chk(tuneBusy, 1'b0);
		end
		for (int c = 0; c < 12; c++) begin
			tune(c[3:0], c[0]);
		end
		// automatic start on frequency writes only
		acc(1'b1, IDX_TUNE, 32'h00000002);
		acc(1'b1, IDX_FREQ_FIRST, 32'h0000005A);
		chk(tuneBusy, 1'b1);
		waitIdle(n);
		acc(1'b1, IDX_FREQ_LAST, 32'h00000011);
		chk(tuneBusy, 1'b1);
		waitIdle(n);
		acc(1'b1, 5'h0B, 32'h000000FF);
		chk(tuneBusy, 1'b0);
		acc(1'b0, IDX_FREQ_FIRST, 32'h0);
		chk(r, 32'h0000005A);
		acc(1'b0, 5'h1F, 32'h0);
		chk(r, 32'h0);
		chk(tuneValid, 1'b1);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		chk(tuneValid, 1'b0);
		tally_and_finish();
	end
endmodule

// ==== test/wb_host.sv ====
// Purpose: bus host model driving the register port
// Assumes: classic Wishbone, one access at a time
// Notes: waits for ack under a bound and reports a hang

module wb_host (
	// clock
	input wire logic clk_sys,
	// bus
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [6:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic ack,
	input wire logic [31:0] datIn
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 7'h00;
		sel = 4'h0;
		dat = 32'h00000000;
	end

	// one access; request held until ack is sampled, then one idle cycle
	task automatic xfer(input logic w, input logic [4:0] idx, input logic [31:0] wd,
		output logic [31:0] rv, output bit hung);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= 4'hF;
		dat <= wd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rv = datIn;
		hung = (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
	endtask
endmodule
